// ==== pkg/therm_pkg.sv ====
package therm_pkg;
	// Clock rate and the two documented times, with their cycle counts derived here.
	localparam int CLK_KHZ = 50000;
	localparam int CONV_TIME_MS = 200;
	localparam int CONV_CYC = CONV_TIME_MS * CLK_KHZ;
	localparam int SPU_MAX_US = 10;
	localparam int SPU_MAX_CYC = SPU_MAX_US * CLK_KHZ / 1000;

	// Slot timing of the wire, in clock cycles; slot times count from the falling edge, presence times from the release, recovery from slot end.
	localparam logic [7:0] RST_LOW_CYC = 8'h30;
	localparam logic [7:0] RST_DET_CYC = 8'h20;
	localparam logic [7:0] PRES_DLY_CYC = 8'h04;
	localparam logic [7:0] PRES_LEN_CYC = 8'h10;
	localparam logic [7:0] PRES_SMP_CYC = 8'h0c;
	localparam logic [7:0] PRES_WIN_CYC = 8'h28;
	localparam logic [7:0] W0_LOW_CYC = 8'h0c;
	localparam logic [7:0] W1_LOW_CYC = 8'h02;
	localparam logic [7:0] SAMPLE_CYC = 8'h06;
	localparam logic [7:0] RD0_HOLD_CYC = 8'h0a;
	localparam logic [7:0] SLOT_CYC = 8'h10;
	localparam logic [7:0] REC_CYC = 8'h02;

	// Identity-code commands.
	localparam logic [7:0] ROM_READ = 8'h33;
	localparam logic [7:0] ROM_MATCH = 8'h55;
	localparam logic [7:0] ROM_SEARCH = 8'hf0;
	localparam logic [7:0] ROM_SKIP = 8'hcc;
	localparam logic [7:0] ROM_ALARM = 8'hec;
	// Memory and control commands.
	localparam logic [7:0] FN_CONVERT = 8'h44;
	localparam logic [7:0] FN_WRITE = 8'h4e;
	localparam logic [7:0] FN_READ = 8'hbe;
	localparam logic [7:0] FN_COPY = 8'h48;
	localparam logic [7:0] FN_RECALL = 8'hb8;
	localparam logic [7:0] FN_POWER = 8'hb4;

	// Reset and fixed scratchpad contents.
	localparam logic [8:0] TEMP_RST = 9'h000;
	localparam logic [7:0] NV_HIGH_RST = 8'h7f;
	localparam logic [7:0] NV_LOW_RST = 8'h80;
	localparam logic [7:0] RESERVED_BYTE = 8'hff;
	localparam logic [7:0] COUNT_REMAIN = 8'h0c;
	localparam logic [7:0] COUNT_PER_C = 8'h10;

	// Controller register map and fields.
	localparam logic [4:0] REG_CMD = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h04;
	localparam logic [4:0] REG_RXDATA = 5'h08;
	localparam logic [4:0] REG_CTRL = 5'h0c;
	localparam int CMD_OP_LSB = 8;
	localparam int CTRL_SPU_AUTO = 0;
	localparam int CTRL_CRC_CLR = 1;

	// Reflected form of x^8+x^5+x^4+1, shifted LSB first.
	localparam logic [7:0] CRC_POLY = 8'h8c;

	typedef enum logic [2:0] {OP_RESET, OP_WRBYTE, OP_RDBYTE, OP_WRBIT, OP_RDBIT} host_op_t;

	function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic b);
		logic fb;
		fb = c[0] ^ b;
		crc8_step = (c >> 1) ^ (fb ? CRC_POLY : 8'h00);
	endfunction

	function automatic logic [7:0] crc8_calc(input logic [63:0] d, input int nbits);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < nbits; i++) begin
			c = crc8_step(c, d[i]);
		end
		crc8_calc = c;
	endfunction
endpackage

// ==== pkg/therm_link_if.sv ====
`timescale 1ns/10ps
// Single open-drain data wire with a pull-up, plus the master's strong pull-up switch.
interface therm_link_if;
	logic m_dq_out;
	logic m_dq_oe;
	logic d_dq_out;
	logic d_dq_oe;
	logic spu;
	logic dq;

	// Wired-AND: any enabled driver wins over the pull-up.
	assign dq = (m_dq_oe ? m_dq_out : 1'b1) & (d_dq_oe ? d_dq_out : 1'b1);

	modport master (output m_dq_out, output m_dq_oe, output spu, input dq);
	modport device (output d_dq_out, output d_dq_oe, input dq, input spu);
endinterface

// ==== rtl/crc8_serial.sv ====
`timescale 1ns/10ps
module crc8_serial
	import therm_pkg::*;
#(
	parameter logic [7:0] POLY = CRC_POLY
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic clear_i,
	input wire logic bit_valid_i,
	input wire logic bit_i,
	output logic [7:0] crc_o
);
	// One shift per wire bit; a clear wins so software can restart a check.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			crc_o <= 8'h00;
		end else if (ce_i) begin
			if (clear_i) begin
				crc_o <= 8'h00;
			end else if (bit_valid_i) begin
				crc_o <= (crc_o >> 1) ^ ((crc_o[0] ^ bit_i) ? POLY : 8'h00);
			end
		end
	end
endmodule // crc8_serial

// ==== rtl/therm_device.sv ====
// Our own choices: the default family code and serial number.
`timescale 1ns/10ps
module therm_device
	import therm_pkg::*;
#(
	parameter logic [7:0] FAMILY_CODE = 8'h5a, // Arbitrary value.
	parameter logic [47:0] SERIAL_NUMBER = 48'h0123_4567_89ab, // Arbitrary value.
	parameter int CONV_CYCLES = CONV_CYC
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	therm_link_if.device link,
	input wire logic [8:0] temp_i,
	input wire logic vdd_present_i,
	output logic alarm_o,
	output logic conv_busy_o,
	output logic [7:0] high_alarm_limit_o,
	output logic [7:0] low_alarm_limit_o
);
	typedef enum {D_IDLE, D_RESET, D_PRES, D_ROM_CMD, D_ROM_TX, D_MATCH, D_SEARCH,
		D_FN_CMD, D_FN_TX, D_FN_RX, D_DONE} dev_state_t;
	typedef enum {SRC_SCRATCH, SRC_CONV, SRC_POWER} tx_src_t;

	dev_state_t state;
	tx_src_t src;
	logic prev_dq;
	logic [7:0] lowcnt;
	logic [7:0] slotcnt;
	logic slot_live;
	logic [7:0] pcnt;
	logic [6:0] idx;
	logic [1:0] phase;
	logic [7:0] sh;
	logic [8:0] temp;
	logic [7:0] sc_high;
	logic [7:0] sc_low;
	logic [23:0] conv_cnt;
	logic fall;
	logic rst_seen;
	logic samp;
	logic byte_done;
	logic [7:0] rx_byte;
	logic [63:0] rom;
	logic [71:0] scratch;
	logic tx_active;
	logic tx_bit;

	// The wire level is taken as synchronous; edges and low time come from one stage.
	assign fall = prev_dq & ~link.dq;
	assign rst_seen = (lowcnt == RST_DET_CYC);
	assign samp = slot_live && (slotcnt == SAMPLE_CYC);
	assign rx_byte = {link.dq, sh[7:1]};
	assign byte_done = samp && (idx[2:0] == 3'h7);
	assign link.d_dq_out = 1'b0;

	// Identity code: family first, serial next, check byte over both on top.
	assign rom[55:0] = {SERIAL_NUMBER, FAMILY_CODE};
	assign rom[63:56] = crc8_calc({8'h00, rom[55:0]}, 56);

	// Scratchpad image; the sign bit is extended through the upper byte.
	assign scratch[63:0] = {COUNT_PER_C, COUNT_REMAIN, RESERVED_BYTE, RESERVED_BYTE,
		sc_low, sc_high, {8{temp[8]}}, temp[7:0]};
	assign scratch[71:64] = crc8_calc(scratch[63:0], 64);

	// Choose the bit this end offers in the next slot; a 1 means leave the wire alone.
	always_comb begin
		tx_active = 1'b0;
		tx_bit = 1'b1;
		unique case (state)
			D_ROM_TX: begin
				tx_active = 1'b1;
				tx_bit = rom[idx[5:0]];
			end
			D_SEARCH: begin
				tx_active = (phase != 2'h2);
				tx_bit = (phase == 2'h0) ? rom[idx[5:0]] : ~rom[idx[5:0]];
			end
			D_FN_TX: begin
				tx_active = 1'b1;
				unique case (src)
					SRC_SCRATCH: tx_bit = scratch[idx];
					SRC_CONV: tx_bit = ~conv_busy_o;
					SRC_POWER: tx_bit = vdd_present_i;
				endcase
			end
			default: begin
				tx_active = 1'b0;
				tx_bit = 1'b1;
			end
		endcase
	end

	// Edge, low-time and slot counters shared by every protocol state.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			prev_dq <= 1'b1;
			lowcnt <= 8'h00;
			slotcnt <= 8'h00;
			slot_live <= 1'b0;
		end else if (ce_i) begin
			prev_dq <= link.dq;
			if (link.dq) begin
				lowcnt <= 8'h00;
			end else if (lowcnt != 8'hff) begin
				lowcnt <= lowcnt + 8'h01;
			end
			if (fall) begin
				slotcnt <= 8'h01;
				slot_live <= 1'b1;
			end else begin
				if (slotcnt != 8'hff) begin
					slotcnt <= slotcnt + 8'h01;
				end
				if (samp) begin
					slot_live <= 1'b0;
				end
			end
		end
	end

	// Protocol sequencer: reset, identity command, one memory command, then silence; convert and power answers repeat until a bus reset.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state <= D_IDLE;
			src <= SRC_SCRATCH;
			pcnt <= 8'h00;
			idx <= 7'h00;
			phase <= 2'h0;
			sh <= 8'h00;
		end else if (ce_i) begin
			if (rst_seen) begin
				state <= D_RESET;
			end else begin
				unique case (state)
					D_IDLE, D_DONE: begin
						state <= state; // Only a bus reset leaves here.
					end
					D_RESET: begin
						if (link.dq) begin
							state <= D_PRES;
							pcnt <= 8'h00;
						end
					end
					D_PRES: begin
						pcnt <= pcnt + 8'h01;
						if (pcnt == PRES_DLY_CYC + PRES_LEN_CYC) begin
							state <= D_ROM_CMD;
							idx <= 7'h00;
						end
					end
					D_ROM_CMD: begin
						if (samp) begin
							sh <= rx_byte;
							idx <= idx + 7'h01;
						end
						if (byte_done) begin
							idx <= 7'h00;
							phase <= 2'h0;
							if (rx_byte == ROM_READ) begin
								state <= D_ROM_TX;
							end else if (rx_byte == ROM_MATCH) begin
								state <= D_MATCH;
							end else if (rx_byte == ROM_SEARCH) begin
								state <= D_SEARCH;
							end else if (rx_byte == ROM_ALARM) begin
								state <= alarm_o ? D_SEARCH : D_DONE;
							end else if (rx_byte == ROM_SKIP) begin
								state <= D_FN_CMD;
							end else begin
								state <= D_DONE;
							end
						end
					end
					D_ROM_TX: begin
						if (samp) begin
							idx <= idx + 7'h01;
							if (idx == 7'd63) begin
								state <= D_FN_CMD;
								idx <= 7'h00;
							end
						end
					end
					D_MATCH: begin
						if (samp) begin
							idx <= idx + 7'h01;
							if (link.dq != rom[idx[5:0]]) begin
								state <= D_DONE; // Another code is being addressed.
							end else if (idx == 7'd63) begin
								state <= D_FN_CMD;
								idx <= 7'h00;
							end
						end
					end
					D_SEARCH: begin
						if (samp) begin
							if (phase != 2'h2) begin
								phase <= phase + 2'h1;
							end else begin
								phase <= 2'h0;
								idx <= idx + 7'h01;
								if (link.dq != rom[idx[5:0]]) begin
									state <= D_DONE; // Master took the other branch.
								end else if (idx == 7'd63) begin
									state <= D_FN_CMD;
									idx <= 7'h00;
								end
							end
						end
					end
					D_FN_CMD: begin
						if (samp) begin
							sh <= rx_byte;
							idx <= idx + 7'h01;
						end
						if (byte_done) begin
							idx <= 7'h00;
							if (rx_byte == FN_CONVERT) begin
								state <= D_FN_TX;
								src <= SRC_CONV;
							end else if (rx_byte == FN_WRITE) begin
								state <= D_FN_RX;
							end else if (rx_byte == FN_READ) begin
								state <= D_FN_TX;
								src <= SRC_SCRATCH;
							end else if (rx_byte == FN_POWER) begin
								state <= D_FN_TX;
								src <= SRC_POWER;
							end else begin
								state <= D_DONE; // Copy, recall and unknown codes end here.
							end
						end
					end
					D_FN_TX: begin
						if (samp) begin
							idx <= (idx == 7'd127) ? idx : idx + 7'h01;
							if (src == SRC_SCRATCH && idx == 7'd71) begin
								state <= D_DONE;
							end
						end
					end
					D_FN_RX: begin
						if (samp) begin
							sh <= rx_byte;
							idx <= idx + 7'h01;
							if (idx == 7'd15) begin
								state <= D_DONE;
							end
						end
					end
				endcase
			end
		end
	end

	// Wire driver: presence pulse, or a zero held through the master's sample point.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			link.d_dq_oe <= 1'b0;
		end else if (ce_i) begin
			if (rst_seen) begin
				link.d_dq_oe <= 1'b0;
			end else if (state == D_PRES) begin
				link.d_dq_oe <= (pcnt >= PRES_DLY_CYC) &&
					(pcnt < PRES_DLY_CYC + PRES_LEN_CYC);
			end else if (fall && tx_active && !tx_bit) begin
				link.d_dq_oe <= 1'b1;
			end else if (slotcnt == RD0_HOLD_CYC) begin
				link.d_dq_oe <= 1'b0;
			end
		end
	end

	// Scratchpad limits and their nonvolatile copies; reads only go via the scratchpad.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sc_high <= NV_HIGH_RST;
			sc_low <= NV_LOW_RST;
			high_alarm_limit_o <= NV_HIGH_RST;
			low_alarm_limit_o <= NV_LOW_RST;
		end else if (ce_i) begin
			if (state == D_FN_RX && byte_done) begin
				if (!idx[3]) begin
					sc_high <= rx_byte;
				end else begin
					sc_low <= rx_byte;
				end
			end
			if (state == D_FN_CMD && byte_done && rx_byte == FN_COPY) begin
				high_alarm_limit_o <= sc_high;
				low_alarm_limit_o <= sc_low;
			end
			if (state == D_FN_CMD && byte_done && rx_byte == FN_RECALL) begin
				sc_high <= high_alarm_limit_o;
				sc_low <= low_alarm_limit_o;
			end
		end
	end

	// Conversion timer; it runs on regardless of bus traffic, so other devices can talk.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			conv_busy_o <= 1'b0;
			conv_cnt <= 24'h000000;
			temp <= TEMP_RST;
			alarm_o <= 1'b0;
		end else if (ce_i) begin
			if (!conv_busy_o) begin
				if (state == D_FN_CMD && byte_done && rx_byte == FN_CONVERT) begin
					conv_busy_o <= 1'b1;
					conv_cnt <= 24'h000000;
				end
			end else if (conv_cnt == 24'(CONV_CYCLES - 1)) begin
				conv_busy_o <= 1'b0;
				temp <= temp_i;
				alarm_o <= ($signed(temp_i[8:1]) > $signed(sc_high)) ||
					($signed(temp_i[8:1]) < $signed(sc_low));
			end else begin
				conv_cnt <= conv_cnt + 24'h000001;
			end
		end
	end
endmodule // therm_device

// ==== rtl/therm_host.sv ====
`timescale 1ns/10ps
module therm_host
	import therm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	therm_link_if.master link,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);
	typedef enum {H_IDLE, H_RST_LOW, H_RST_WAIT, H_SLOT, H_RECOVER} host_state_t;

	host_state_t hstate;
	host_op_t op;
	logic [10:0] cmd_last;
	logic [7:0] txsh;
	logic [7:0] rxsh;
	logic [7:0] rxdata;
	logic [3:0] bits;
	logic [7:0] cnt;
	logic presence;
	logic spu_auto;
	logic [7:0] crc;
	logic busy;
	logic acc;
	logic acc_cmd;
	logic acc_ctrl;
	logic [2:0] cmd_op;
	logic [31:0] rdmux;
	logic byte_op;

	assign busy = (hstate != H_IDLE);
	assign acc = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
	assign acc_cmd = acc && avs_write_i && avs_address_i == REG_CMD;
	assign acc_ctrl = acc && avs_write_i && avs_address_i == REG_CTRL;
	assign cmd_op = avs_writedata_i[CMD_OP_LSB +: 3];
	assign byte_op = (op == OP_WRBYTE) || (op == OP_RDBYTE);
	assign link.m_dq_out = 1'b0;

	// Read data; unmapped offsets read as zero.
	always_comb begin
		unique case (avs_address_i)
			REG_CMD: rdmux = {21'h000000, cmd_last};
			REG_STATUS: rdmux = {28'h0000000, crc == 8'h00, link.spu, presence, busy};
			REG_RXDATA: rdmux = {24'h000000, rxdata};
			REG_CTRL: rdmux = {31'h00000000, spu_auto};
			default: rdmux = 32'h00000000;
		endcase
	end

	// Slave handshake: waitrequest drops one cycle after a request, and a command
	// write is held off while the wire is busy so none is lost.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h00000000;
		end else if (ce_i) begin
			if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
				if (!(avs_write_i && avs_address_i == REG_CMD && busy)) begin
					avs_waitrequest_o <= 1'b0;
					avs_readdata_o <= rdmux;
				end
			end else begin
				avs_waitrequest_o <= 1'b1;
			end
		end
	end

	// Control register.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			spu_auto <= 1'b0;
		end else if (ce_i && acc_ctrl) begin
			spu_auto <= avs_writedata_i[CTRL_SPU_AUTO]; // Set after a 0 power answer.
		end
	end

	// Check value over every sampled wire bit.
	crc8_serial u_crc (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.clear_i(acc_ctrl && avs_writedata_i[CTRL_CRC_CLR]),
		.bit_valid_i(hstate == H_SLOT && cnt == SAMPLE_CYC),
		.bit_i(link.dq),
		.crc_o(crc)
	);

	// Wire engine: reset pulse with presence sampling, and bit slots LSB first.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			hstate <= H_IDLE;
			op <= OP_RESET;
			cmd_last <= 11'h000;
			txsh <= 8'hff;
			rxsh <= 8'h00;
			rxdata <= 8'h00;
			bits <= 4'h0;
			cnt <= 8'h00;
			presence <= 1'b0;
			link.m_dq_oe <= 1'b0;
			link.spu <= 1'b0;
		end else if (ce_i) begin
			unique case (hstate)
				H_IDLE: begin
					if (acc_cmd && cmd_op <= OP_RDBIT) begin
						op <= host_op_t'(cmd_op);
						cmd_last <= avs_writedata_i[10:0];
						txsh <= (cmd_op == OP_WRBYTE || cmd_op == OP_WRBIT) ?
							avs_writedata_i[7:0] : 8'hff;
						bits <= (cmd_op == OP_WRBYTE || cmd_op == OP_RDBYTE) ? 4'h8 : 4'h1;
						cnt <= 8'h00;
						link.spu <= 1'b0;
						link.m_dq_oe <= 1'b1;
						hstate <= (cmd_op == OP_RESET) ? H_RST_LOW : H_SLOT;
					end
				end
				H_RST_LOW: begin
					cnt <= cnt + 8'h01;
					if (cnt == RST_LOW_CYC - 8'h01) begin
						link.m_dq_oe <= 1'b0;
						cnt <= 8'h00;
						hstate <= H_RST_WAIT;
					end
				end
				H_RST_WAIT: begin
					cnt <= cnt + 8'h01;
					if (cnt == PRES_SMP_CYC) begin
						presence <= !link.dq;
					end
					if (cnt == PRES_WIN_CYC - 8'h01) begin
						hstate <= H_IDLE;
					end
				end
				H_SLOT: begin
					cnt <= cnt + 8'h01;
					if (cnt == (txsh[0] ? W1_LOW_CYC : W0_LOW_CYC) - 8'h01) begin
						link.m_dq_oe <= 1'b0;
					end
					if (cnt == SAMPLE_CYC) begin
						rxsh <= {link.dq, rxsh[7:1]};
					end
					if (cnt == SLOT_CYC - 8'h01) begin
						txsh <= {1'b1, txsh[7:1]};
						bits <= bits - 4'h1;
						cnt <= 8'h00;
						hstate <= H_RECOVER;
					end
				end
				H_RECOVER: begin
					cnt <= cnt + 8'h01;
					if (cnt == REC_CYC - 8'h01) begin
						cnt <= 8'h00;
						if (bits == 4'h0) begin
							hstate <= H_IDLE;
							rxdata <= byte_op ? rxsh : {7'h00, rxsh[7]};
							link.spu <= spu_auto && op == OP_WRBYTE &&
								(cmd_last[7:0] == FN_CONVERT || cmd_last[7:0] == FN_COPY);
						end else begin
							link.m_dq_oe <= 1'b1;
							hstate <= H_SLOT;
						end
					end
				end
			endcase
		end
	end
endmodule // therm_host

// ==== verification/therm_properties.sv ====
`timescale 1ns/10ps
// Watches the shared wire between the two ends.
module therm_properties (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic m_dq_out,
	input wire logic m_dq_oe,
	input wire logic d_dq_out,
	input wire logic d_dq_oe,
	input wire logic spu,
	input wire logic dq
);
	logic [7:0] run;
	logic [7:0] drun;
	logic [7:0] per;
	logic oe_q;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// Length of the current low drive of each party.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			run <= 8'h00;
			drun <= 8'h00;
		end else begin
			run <= m_dq_oe ? run + 8'h01 : 8'h00;
			drun <= d_dq_oe ? drun + 8'h01 : 8'h00;
		end
	end

	// Cycles since the master last opened a slot; saturates so a long idle never wraps.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			per <= 8'hff;
			oe_q <= 1'b0;
		end else begin
			oe_q <= m_dq_oe;
			if (m_dq_oe && !oe_q) begin
				per <= 8'h01;
			end else if (per != 8'hff) begin
				per <= per + 8'h01;
			end
		end
	end

	// End of a full-length bus reset pulse.
	sequence reset_end;
		$fell(m_dq_oe) && run == 8'h30;
	endsequence

	a_drive_zero: assert property (!m_dq_out && !d_dq_out)
		else $error("driver value not low");
	a_low_len: assert property ($fell(m_dq_oe) |-> run inside {8'h02, 8'h0c, 8'h30})
		else $error("master low pulse of wrong length");
	a_slot_period: assert property ($rose(m_dq_oe) |-> per >= 8'h12)
		else $error("slots closer than 18 cycles");
	a_spu_excl: assert property (spu |-> !m_dq_oe)
		else $error("strong pull-up while master drives low");
	// The pull-up must follow the last slot of its command closely, far inside 10 us.
	a_spu_prompt: assert property ($rose(spu) |-> per inside {[8'h01:8'h20]})
		else $error("strong pull-up late after command");
	a_dev_len: assert property (d_dq_oe |-> drun < 8'h10)
		else $error("device low drive too long");
	// A reset may open on a slot that the device answers with a zero; only a new drive counts.
	a_dev_quiet: assert property ((m_dq_oe && run >= 8'h02) |-> !$rose(d_dq_oe))
		else $error("device starts driving during master pulse");
	a_presence_go: assert property (reset_end |-> ##[2:8] d_dq_oe)
		else $error("no presence pulse");
	a_presence_shape: assert property (reset_end |-> ##12 !dq ##26 dq)
		else $error("presence window wrong");
endmodule // therm_properties

// ==== verification/tb.sv ====
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
	import therm_pkg::*;
	localparam logic [7:0] FAM = 8'h3c; // Arbitrary value.
	localparam logic [47:0] SER = 48'h0a1b_2c3d_4e5f; // Arbitrary value.
	typedef struct packed {logic [8:0] t; logic v; logic [7:0] h; logic [7:0] l; logic al;} row_t;
	// Temperature, supply, limits and the alarm they should give; two sit on the boundary.
	row_t rows [4] = '{'{9'h032, 1'b1, 8'h1e, 8'h0a, 1'b0}, '{9'h1ce, 1'b0, 8'h1e, 8'h0a, 1'b1},
		'{9'h0fa, 1'b1, 8'h7d, 8'h80, 1'b0}, '{9'h0fa, 1'b0, 8'h7c, 8'h80, 1'b1}};
	row_t r;
	logic clk_i, rst_n_i, avs_read_i, avs_write_i, vdd_i, alarm_o, busy_o, avs_waitrequest_o;
	logic [4:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, rd;
	logic [8:0] temp_i;
	logic [7:0] hi_o, lo_o, c;
	logic [7:0] exp_b [5];
	logic [63:0] code;
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;

	therm_link_if link ();
	therm_device #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER), .CONV_CYCLES(200)) therm_device_i (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .link(link), .temp_i(temp_i),
		.vdd_present_i(vdd_i), .alarm_o(alarm_o), .conv_busy_o(busy_o),
		.high_alarm_limit_o(hi_o), .low_alarm_limit_o(lo_o));
	therm_host therm_host_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .link(link),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o));
	therm_properties therm_properties_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.m_dq_out(link.m_dq_out), .m_dq_oe(link.m_dq_oe), .d_dq_out(link.d_dq_out),
		.d_dq_oe(link.d_dq_oe), .spu(link.spu), .dq(link.dq));

	// Free-running 50 MHz clock, and a cycle ceiling so a stuck handshake still ends the run.
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			give_verdict();
		end
	end

	task give_verdict();
		if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// One bus transfer, held until waitrequest is seen low.
	task av(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_i);
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_address_i <= a;
		avs_writedata_i <= d;
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask

	// Runs one wire operation to completion; leaves the received data in rd.
	task op(input host_op_t o, input logic [7:0] d);
		av(1'b1, REG_CMD, {21'h0, o, d});
		do av(1'b0, REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
		av(1'b0, REG_RXDATA, 32'h0);
	endtask

	task seq(input logic [7:0] a, input logic [7:0] b);
		op(OP_RESET, 8'h00);
		op(OP_WRBYTE, a);
		op(OP_WRBYTE, b);
	endtask

	initial begin
		rst_n_i = 1'b0;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_address_i = 5'h00;
		avs_writedata_i = 32'h0;
		temp_i = 9'h000;
		vdd_i = 1'b0;
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		`CHK(hi_o, NV_HIGH_RST)
		`CHK(lo_o, NV_LOW_RST)
		av(1'b0, 5'h10, 32'h0);
		`CHK(rd, 32'h0)
		// Selection without a bus reset before it is ignored, so the wire reads high.
		op(OP_WRBYTE, ROM_SKIP);
		op(OP_WRBYTE, FN_POWER);
		op(OP_RDBIT, 8'h00);
		`CHK(rd[0], 1'b1)
		op(OP_RESET, 8'h00);
		av(1'b0, REG_STATUS, 32'h0);
		`CHK(rd[1], 1'b1)
		op(OP_WRBYTE, FN_POWER);
		op(OP_RDBIT, 8'h00);
		`CHK(rd[0], 1'b1)
		// Identity code with its check byte worked out here.
		code = {8'h00, SER, FAM};
		c = 8'h00;
		for (int i = 0; i < 56; i++) c = (c >> 1) ^ ((c[0] ^ code[i]) ? 8'h8c : 8'h00);
		code[63:56] = c;
		op(OP_RESET, 8'h00);
		op(OP_WRBYTE, ROM_READ);
		// Restart the check value so it covers exactly the 64 code bits.
		av(1'b1, REG_CTRL, 32'h2);
		for (int i = 0; i < 8; i++) begin
			op(OP_RDBYTE, 8'h00);
			`CHK(rd[7:0], code[8*i+:8])
		end
		av(1'b0, REG_STATUS, 32'h0);
		`CHK(rd[3], 1'b1)
		av(1'b1, REG_CTRL, 32'h1);
		// Each row: store limits, convert, read back, alarm search and power query.
		for (int k = 0; k < 4; k++) begin
			r = rows[k];
			temp_i <= r.t;
			vdd_i <= r.v;
			seq(ROM_SKIP, FN_WRITE);
			op(OP_WRBYTE, r.h);
			op(OP_WRBYTE, r.l);
			seq(ROM_SKIP, FN_COPY);
			`CHK(link.spu, 1'b1)
			`CHK(hi_o, r.h)
			`CHK(lo_o, r.l)
			seq(ROM_SKIP, FN_CONVERT);
			`CHK(busy_o, 1'b1)
			do op(OP_RDBIT, 8'h00); while (rd[0] !== 1'b1);
			`CHK(alarm_o, r.al)
			seq(ROM_SKIP, FN_READ);
			exp_b = '{r.t[7:0], {8{r.t[8]}}, r.h, r.l, RESERVED_BYTE};
			for (int i = 0; i < 5; i++) begin
				op(OP_RDBYTE, 8'h00);
				`CHK(rd[7:0], exp_b[i])
			end
			op(OP_RESET, 8'h00);
			op(OP_WRBYTE, ROM_ALARM);
			op(OP_RDBIT, 8'h00);
			`CHK(rd[0], r.al ? FAM[0] : 1'b1)
			op(OP_RDBIT, 8'h00);
			`CHK(rd[0], r.al ? !FAM[0] : 1'b1)
			seq(ROM_SKIP, FN_POWER);
			op(OP_RDBIT, 8'h00);
			`CHK(rd[0], r.v)
		end
		// A second memory command in one transaction is ignored.
		seq(ROM_SKIP, FN_RECALL);
		op(OP_WRBYTE, FN_POWER);
		op(OP_RDBIT, 8'h00);
		`CHK(rd[0], 1'b1)
		op(OP_RESET, 8'h00);
		op(OP_WRBYTE, ROM_MATCH);
		for (int i = 0; i < 8; i++) op(OP_WRBYTE, code[8*i+:8]);
		op(OP_WRBYTE, FN_POWER);
		op(OP_RDBIT, 8'h00);
		`CHK(rd[0], 1'b0)
		// Search: each code bit comes true then inverted, and the master follows it.
		op(OP_RESET, 8'h00);
		op(OP_WRBYTE, ROM_SEARCH);
		for (int i = 0; i < 64; i++) begin
			op(OP_RDBIT, 8'h00);
			`CHK(rd[0], code[i])
			op(OP_RDBIT, 8'h00);
			`CHK(rd[0], !code[i])
			op(OP_WRBIT, {7'h00, code[i]});
		end
		op(OP_WRBYTE, FN_POWER);
		op(OP_RDBIT, 8'h00);
		`CHK(rd[0], r.v)
		give_verdict();
	end
endmodule // tb
